// ---- verification/analog_front_model.sv ----
// behavioural sample-and-hold and comparator that answer the converter's trials
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
  // clock
  input wire logic clock,
  // converter side
  input wire logic [adc_host_pkg::CHAN_COUNT-1:0] analog_input_en,
  input wire logic sample_hold,
  input wire logic [adc_host_pkg::RESULT_W-1:0] dac_code,
  output logic cmp_keep,
  // bench side: one input level per channel
  input wire logic [adc_host_pkg::RESULT_W-1:0] level [adc_host_pkg::CHAN_COUNT]
);
  import adc_host_pkg::*;
  logic [RESULT_W-1:0] held_q;
  logic [RESULT_W-1:0] picked;
  always_comb begin
    picked = level[0];
    for (int i = 0; i < CHAN_COUNT; i++) begin
      if (analog_input_en[i]) begin
        picked = level[i];
      end
    end
  end
  // the level is frozen once sampling ends, so a later level change cannot leak in
  always_ff @(posedge clock) begin
    if (sample_hold) begin
      held_q <= picked;
    end
  end
  assign cmp_keep = (held_q >= dac_code);
endmodule
`default_nettype wire

// ---- verification/test_parallel_adc_host_interface.sv ----
// self-checking bench for the converter host interface
`timescale 1ns/10ps
`default_nettype none
module test_parallel_adc_host_interface;
  import adc_host_pkg::*;
  logic clock, resetn, cs_n, wr_n, rd_n, channel_sel_lo, channel_sel_hi;
  logic busy_n, result_oe, sample_hold, cmp_keep;
  logic [RESULT_W-1:0] result_out, dac_code, prev;
  logic [CHAN_COUNT-1:0] analog_input_en;
  logic [RESULT_W-1:0] level [CHAN_COUNT];
  logic [RESULT_W-1:0] corner [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
  logic [RESULT_W-1:0] seen [$];
  int bad_count = 0;
  int cmp_count = 0;
  int unsigned seed;
  int ch;
  parallel_adc_host_interface i_dut (.clock(clock), .resetn(resetn), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .channel_sel_lo(channel_sel_lo),
    .channel_sel_hi(channel_sel_hi), .busy_n(busy_n), .result_out(result_out),
    .result_oe(result_oe), .analog_input_en(analog_input_en), .sample_hold(sample_hold),
    .dac_code(dac_code), .cmp_keep(cmp_keep));
  analog_front_model i_front (.clock(clock), .analog_input_en(analog_input_en),
    .sample_hold(sample_hold), .dac_code(dac_code), .cmp_keep(cmp_keep), .level(level));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      $display("[ERR] %0t %s", $time, msg);
      bad_count++;
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // rd_low keeps a read open across the start, which must still float the bus
  task automatic start_conv(input int c, input bit rd_low);
    step();
    {channel_sel_hi, channel_sel_lo} = c[1:0];
    cs_n = 1'b0;
    wr_n = 1'b0;
    rd_n = ~rd_low;
    #1;
    check(result_oe === 1'b0, "bus driven at start");
    step();
    wr_n = 1'b1;
    cs_n = ~rd_low;
  endtask
  task automatic finish_conv(input int c, input bit probe);
    int n;
    for (n = 2; n < 40; n++) begin
      step();
      if (busy_n === 1'b1) break;
      check(busy_n === 1'b0, "busy not low");
      check(sample_hold === (n <= 3), "sample phase");
      if (n == 4) check(dac_code === 12'h800, "first trial code");
      if (n >= 3) check(analog_input_en === 4'h1 << c, "wrong input");
      if (probe && n == 6) {cs_n, rd_n} = 2'b00;
      if (probe && n >= 7) check(result_oe === 1'b0, "bus driven while busy");
      if (probe && n == 9) {cs_n, rd_n} = 2'b11;
    end
    check(n == 17, "conversion length");
    if (n == 40) complete_run();
  endtask
  task automatic read_check(input logic [RESULT_W-1:0] exp);
    step();
    {cs_n, rd_n} = 2'b00;
    #1;
    check(result_oe === 1'b1, "read not driven");
    check(result_out === exp, "result word");
    step();
    {cs_n, rd_n} = 2'b11;
    #1;
    check(result_oe === 1'b0, "bus not floated");
  endtask
  initial begin
    {resetn, cs_n, wr_n, rd_n, channel_sel_lo, channel_sel_hi} = 6'b011100;
    seed = $urandom(77);
    for (int i = 0; i < CHAN_COUNT; i++) level[i] = RESULT_W'($urandom);
    repeat (4) @(posedge clock);
    #1;
    resetn = 1'b1;
    check(busy_n === 1'b1 && result_oe === 1'b0, "reset state");
    // pins are taken on the strobe's rise only, even with select high
    for (int c = 0; c < CHAN_COUNT; c++) begin
      for (int s = 0; s < 2; s++) begin
        step();
        {channel_sel_hi, channel_sel_lo} = c[1:0];
        if (s == 0) rd_n = 1'b0;
        else wr_n = 1'b0;
        step();
        {rd_n, wr_n} = 2'b11;
        step();
        {channel_sel_hi, channel_sel_lo} = 2'(3 - c);
        step();
        check(analog_input_en === 4'h1 << c, "strobe capture");
      end
    end
    for (int i = 0; i < 8; i++) begin
      ch = (i < 4) ? i : $urandom_range(3);
      level[ch] = (i < 4) ? corner[i] : RESULT_W'($urandom);
      start_conv(ch, 1'b0);
      finish_conv(ch, 1'b1);
      read_check(level[ch]);
    end
    // restart mid conversion: only the second channel's word may appear
    level[3] = ~level[0];
    start_conv(0, 1'b0);
    repeat (5) step();
    start_conv(3, 1'b0);
    finish_conv(3, 1'b0);
    read_check(level[3]);
    // a held read parks words in the buffer; the third conversion must stall
    // each word differs from the one shown before it, so every change is seen
    level[1] = ~level[3];
    level[2] = level[3] ^ 12'h0F0;
    level[3] = level[3] ^ 12'hF00;
    start_conv(1, 1'b1);
    finish_conv(1, 1'b0);
    start_conv(2, 1'b1);
    finish_conv(2, 1'b0);
    start_conv(3, 1'b1);
    repeat (25) step();
    check(busy_n === 1'b0, "full buffer not stalling");
    prev = result_out;
    {cs_n, rd_n} = 2'b11;
    repeat (30) begin
      step();
      if (result_out !== prev) seen.push_back(result_out);
      prev = result_out;
    end
    check(seen.size() == 3 && busy_n === 1'b1, "buffer drain");
    for (int i = 0; i < seen.size() && i < 3; i++) begin
      check(seen[i] === level[i + 1], "buffered order");
    end
    complete_run();
  end
endmodule
`default_nettype wire

// ---- verilog/adc_host_pkg.sv ----
// constants and types shared by the converter host interface and its result buffer
package adc_host_pkg;

  // result word and channel address widths
  localparam int RESULT_W = 12;
  localparam int CHAN_W = 2;
  localparam int CHAN_COUNT = 4;

  // channel codes, high select bit first
  localparam logic [CHAN_W-1:0] CHAN_INPUT_0 = 2'h0;
  localparam logic [CHAN_W-1:0] CHAN_INPUT_1 = 2'h1;
  localparam logic [CHAN_W-1:0] CHAN_INPUT_2 = 2'h2;
  localparam logic [CHAN_W-1:0] CHAN_INPUT_3 = 2'h3;

  // timing: the conversion clock runs at sixteen times the sample rate
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int CLOCKS_PER_SAMPLE = 16;
  localparam int SAMPLE_PERIOD_NS = CLOCK_PERIOD_NS * CLOCKS_PER_SAMPLE;
  localparam int CONV_CYCLES = SAMPLE_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int SAMPLE_CYCLES = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] TRIAL_LAST = CNT_W'(SAMPLE_CYCLES + RESULT_W - 1);

  // result buffer
  localparam int BUF_DEPTH = 2;

  // reset values
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [CHAN_W-1:0] CHAN_RESET = CHAN_INPUT_0;

  // conversion sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_SAMPLE = 2'b01,
    CONV_TRIAL = 2'b10,
    CONV_DONE = 2'b11
  } conv_state_t;

endpackage

// ---- verilog/parallel_adc_host_interface.sv ----
// host strobe decoding and conversion sequencing of a four-channel 12-bit converter
// What this block does
// - with select and read strobe both low and busy high the result word is driven on the data outputs, except in the cycle a conversion starts.
// - select and convert strobe both low start a new conversion and float the data outputs.
// - the channel pins presented during the convert strobe pick the input converted.
// - busy goes low when a conversion starts and stays low for the whole conversion.
// - at the end of a conversion busy rises; the new result reaches the output word one clock later at the earliest, and only while no read is under way.
// - one conversion spans sixteen clock periods unless a full buffer stalls the hand-off, the clock being sixteen times the rate.
// - the channel pins are captured on the rising edge of the read or the convert strobe.
// - channel codes 00, 01, 10, 11 select inputs 0, 1, 2, 3, high bit first.
`timescale 1ns/10ps
`default_nettype none
module parallel_adc_host_interface (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // host strobes and channel address
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic channel_sel_lo,
  input wire logic channel_sel_hi,
  output logic busy_n,
  // three-state result bus
  output logic [adc_host_pkg::RESULT_W-1:0] result_out,
  output logic result_oe,
  // analog front end
  output logic [adc_host_pkg::CHAN_COUNT-1:0] analog_input_en,
  output logic sample_hold,
  output logic [adc_host_pkg::RESULT_W-1:0] dac_code,
  input wire logic cmp_keep
);
  import adc_host_pkg::*;

  // one-hot trial bit for a sequencer count, zero outside the trial steps
  function automatic logic [RESULT_W-1:0] trial_mask(input logic [CNT_W-1:0] cnt);
    logic [CNT_W-1:0] pos;
    pos = TRIAL_LAST - cnt;
    if (cnt > SAMPLE_LAST && cnt <= TRIAL_LAST) begin
      trial_mask = RESULT_W'(1) << pos;
    end else begin
      trial_mask = '0;
    end
  endfunction

  // channel code to input enable, high select bit first
  function automatic logic [CHAN_COUNT-1:0] chan_onehot(input logic [CHAN_W-1:0] code);
    chan_onehot = CHAN_COUNT'(1) << code;
  endfunction

  result_stream_if fill ();
  result_stream_if drain ();

  result_buffer u_buffer (
    .clock(clock),
    .resetn(resetn),
    .fill(fill),
    .drain(drain)
  );

  // strobe edge detection
  logic wr_n_q, wr_n_d;
  logic rd_n_q, rd_n_d;
  logic conv_strobe_q, conv_strobe_d;
  logic conv_strobe;
  logic start;
  logic wr_rise;
  logic rd_rise;
  logic read_active;
  logic [CHAN_W-1:0] chan_pins;

  assign conv_strobe = ~cs_n & ~wr_n;
  assign start = conv_strobe & ~conv_strobe_q;
  assign wr_rise = wr_n & ~wr_n_q;
  assign rd_rise = rd_n & ~rd_n_q;
  assign read_active = ~cs_n & ~rd_n;
  assign chan_pins = {channel_sel_hi, channel_sel_lo};

  always_comb begin
    wr_n_d = wr_n;
    rd_n_d = rd_n;
    conv_strobe_d = conv_strobe;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      conv_strobe_q <= 1'b0;
    end else begin
      wr_n_q <= wr_n_d;
      rd_n_q <= rd_n_d;
      conv_strobe_q <= conv_strobe_d;
    end
  end

  // channel address latch
  logic [CHAN_W-1:0] chan_q, chan_d;
  logic [CHAN_COUNT-1:0] en_q, en_d;

  always_comb begin
    chan_d = chan_q;
    if (start || wr_rise || rd_rise) begin
      chan_d = chan_pins;
    end
    en_d = chan_onehot(chan_d);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      chan_q <= CHAN_RESET;
      en_q <= chan_onehot(CHAN_RESET);
    end else begin
      chan_q <= chan_d;
      en_q <= en_d;
    end
  end

  assign analog_input_en = en_q;

  // conversion sequencer: sample, twelve trials, hand-off
  conv_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [RESULT_W-1:0] trial_q, trial_d;
  logic [RESULT_W-1:0] dac_q, dac_d;
  logic busy_n_q, busy_n_d;
  logic hold_q, hold_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    trial_d = trial_q;
    case (state_q)
      CONV_IDLE: begin
        cnt_d = '0;
      end
      CONV_SAMPLE: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == SAMPLE_LAST) begin
          state_d = CONV_TRIAL;
        end
      end
      CONV_TRIAL: begin
        if (cmp_keep) begin
          trial_d = trial_q | trial_mask(cnt_q);
        end
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == TRIAL_LAST) begin
          state_d = CONV_DONE;
        end
      end
      CONV_DONE: begin
        // a full buffer holds busy low, so the result waits here until there is room or a new strobe aborts it
        if (fill.ready) begin
          state_d = CONV_IDLE;
        end
      end
      default: begin
        state_d = CONV_IDLE;
      end
    endcase
    if (start) begin
      // a new strobe aborts whatever conversion is running
      state_d = CONV_SAMPLE;
      cnt_d = '0;
      trial_d = '0;
    end
    dac_d = trial_d | trial_mask(cnt_d);
    busy_n_d = (state_d == CONV_IDLE);
    hold_d = (state_d == CONV_SAMPLE);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= CONV_IDLE;
      cnt_q <= '0;
      trial_q <= RESULT_RESET;
      dac_q <= RESULT_RESET;
      busy_n_q <= 1'b1;
      hold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      trial_q <= trial_d;
      dac_q <= dac_d;
      busy_n_q <= busy_n_d;
      hold_q <= hold_d;
    end
  end

  assign fill.valid = (state_q == CONV_DONE);
  assign fill.data = trial_q;
  assign busy_n = busy_n_q;
  assign dac_code = dac_q;
  assign sample_hold = hold_q;

  // read port: the output word only changes while no read is under way
  logic [RESULT_W-1:0] result_q, result_d;

  assign drain.ready = ~read_active;

  always_comb begin
    result_d = result_q;
    if (drain.valid && drain.ready) begin
      result_d = drain.data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      result_q <= RESULT_RESET;
    end else begin
      result_q <= result_d;
    end
  end

  assign result_out = result_q;
  assign result_oe = read_active & busy_n_q & ~start;

  // helper: length of the current busy-low stretch, saturating
  logic [7:0] low_cnt_q;

  always_ff @(posedge clock) begin
    if (!resetn || busy_n_q || start) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  AST_START_FLOATS: assert property (@(posedge clock) disable iff (!resetn)
    start |-> !result_oe ##1 (!busy_n && !result_oe))
    else $error("conversion start did not float the data outputs");

  AST_CHAN_AT_START: assert property (@(posedge clock) disable iff (!resetn)
    start |=> chan_q == $past(chan_pins))
    else $error("channel pins not taken at conversion start");

  AST_BUSY_HOLDS: assert property (@(posedge clock) disable iff (!resetn)
    (start ##1 !start [*7]) |-> !busy_n [*8])
    else $error("busy rose early during a conversion");

  AST_DONE_RESULT: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == CONV_DONE && fill.ready && !start) |=> busy_n && drain.valid)
    else $error("finished result not released with busy");

  AST_CONV_LENGTH: assert property (@(posedge clock) disable iff (!resetn)
    $rose(busy_n) |-> low_cnt_q >= 8'(CONV_CYCLES))
    else $error("conversion shorter than sixteen clocks");

  // the stretch counter stands in for a long repetition; it reads fifteen in the hand-off cycle
  AST_FAST_FINISH: assert property (@(posedge clock) disable iff (!resetn)
    (!busy_n && !start && fill.ready && low_cnt_q == 8'(CONV_CYCLES - 1)) |=> busy_n)
    else $error("unstalled conversion lasted beyond sixteen clocks");

  AST_CHAN_EDGE: assert property (@(posedge clock) disable iff (!resetn)
    (wr_rise || rd_rise) |=> chan_q == $past(chan_pins))
    else $error("channel pins not captured on strobe rising edge");

  AST_CHAN_MAP: assert property (@(posedge clock) disable iff (!resetn)
    (chan_q == CHAN_INPUT_2) |-> analog_input_en == 4'h4)
    else $error("channel code 10 does not enable input 2");

  AST_READ_DRIVES: assert property (@(posedge clock) disable iff (!resetn)
    (read_active && busy_n && !start) |-> result_oe && (!$past(read_active) || $stable(result_out)))
    else $error("read during idle did not drive a steady result");

  AST_FLOAT_OTHERWISE: assert property (@(posedge clock) disable iff (!resetn)
    result_oe |-> (!cs_n && !rd_n && busy_n))
    else $error("data outputs driven outside a read");

  // busy, sampling, trial code, output enable and channel checks that need no long repetition
  AST_BUSY_FALLS: assert property (@(posedge clock) disable iff (!resetn)
    start |=> !busy_n)
    else $error("busy did not fall after a conversion start");

  AST_BUSY_STAYS: assert property (@(posedge clock) disable iff (!resetn)
    (!busy_n && !start && low_cnt_q < 8'(CONV_CYCLES - 1)) |=> !busy_n)
    else $error("busy rose before the conversion finished");

  AST_SAMPLE_WINDOW: assert property (@(posedge clock) disable iff (!resetn)
    start |=> sample_hold [*3])
    else $error("sample phase shorter than three clocks");

  AST_SAMPLE_ENDS: assert property (@(posedge clock) disable iff (!resetn)
    (start ##1 !start [*3]) |=> !sample_hold)
    else $error("sample phase longer than three clocks");

  AST_FIRST_TRIAL: assert property (@(posedge clock) disable iff (!resetn)
    (start ##1 !start [*3]) |=> dac_code == 12'h800)
    else $error("first trial code is not the top bit");

  AST_OE_IN_CONV: assert property (@(posedge clock) disable iff (!resetn)
    !busy_n |-> !result_oe)
    else $error("data outputs driven during a conversion");

  AST_NO_DROP: assert property (@(posedge clock) disable iff (!resetn)
    (fill.valid && !fill.ready) |=> !busy_n)
    else $error("busy rose while the finished word was refused");

  AST_CHAN_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    !(start || wr_rise || rd_rise) |=> $stable(chan_q))
    else $error("channel latch changed without a strobe edge");

endmodule
`default_nettype wire

// ---- verilog/result_buffer.sv ----
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module result_buffer (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // streams
  result_stream_if.snk fill,
  result_stream_if.src drain
);
  import adc_host_pkg::*;

  logic [RESULT_W-1:0] mem_q [BUF_DEPTH];
  logic [RESULT_W-1:0] mem_d [BUF_DEPTH];
  logic wr_ptr_q, wr_ptr_d;
  logic rd_ptr_q, rd_ptr_d;
  logic [1:0] count_q, count_d;
  logic push, pop;

  assign fill.ready = (count_q != 2'(BUF_DEPTH));
  assign drain.valid = (count_q != 2'h0);
  assign drain.data = mem_q[rd_ptr_q];

  always_comb begin
    push = fill.valid & fill.ready;
    pop = drain.valid & drain.ready;
    mem_d = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wr_ptr_q] = fill.data;
      wr_ptr_d = ~wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = ~rd_ptr_q;
    end
    if (push && !pop) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push) begin
      count_d = count_q - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_q[0] <= RESULT_RESET;
      mem_q[1] <= RESULT_RESET;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/result_stream_if.sv ----
// valid/ready word stream between the sequencer, the buffer and the read port
`timescale 1ns/10ps
`default_nettype none
interface result_stream_if;
  import adc_host_pkg::*;
  logic valid;
  logic ready;
  logic [RESULT_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
